// ===== shared/cmd_decode_pkg.sv
package cmd_decode_pkg;

	// ****************************************
	// Command key patterns (bits 7..4; the three-bit keys are bits 7..5)
	// ****************************************
	localparam logic [3:0] KEY_RESTORE   = 4'h0;
	localparam logic [3:0] KEY_SEEK      = 4'h1;
	localparam logic [2:0] KEY_STEP      = 3'h1;
	localparam logic [2:0] KEY_STEP_IN   = 3'h2;
	localparam logic [2:0] KEY_STEP_OUT  = 3'h3;
	localparam logic [2:0] KEY_RD_SECT   = 3'h4;
	localparam logic [2:0] KEY_WR_SECT   = 3'h5;
	localparam logic [3:0] KEY_RD_ADDR   = 4'hc;
	localparam logic [3:0] KEY_FORCE     = 4'hd;
	localparam logic [3:0] KEY_RD_TRACK  = 4'he;
	localparam logic [3:0] KEY_WR_TRACK  = 4'hf;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_SPINUP_INH = 3;
	localparam int BIT_VERIFY     = 2;
	localparam int BIT_UPDATE     = 4;
	localparam int BIT_MULTI      = 4;
	localparam int BIT_DELETED    = 0;
	localparam int BIT_BUSY       = 0;
	localparam int BIT_ERROR      = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CMD_RESET    = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ****************************************
	// Step intervals (ms) and clock
	// ****************************************
	localparam int CLK_HZ        = 20000000;
	localparam int CYC_PER_MS    = CLK_HZ / 1000;
	localparam int STD_MS_0      = 6;
	localparam int STD_MS_1      = 12;
	localparam int STD_MS_2      = 20;
	localparam int STD_MS_3      = 30;
	localparam int FAST_MS_0     = 6;
	localparam int FAST_MS_1     = 12;
	localparam int FAST_MS_2     = 2;
	localparam int FAST_MS_3     = 3;

	typedef enum logic [2:0] {
		CMD_NONE     = 3'h0,
		CMD_TYPE1    = 3'h1,
		CMD_TYPE2    = 3'h2,
		CMD_TYPE3    = 3'h3,
		CMD_TYPE4    = 3'h4
	} cmd_class_type;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SPINUP = 2'b01,
		ST_EXEC   = 2'b10,
		ST_DONE   = 2'b11
	} seq_state_type;

endpackage : cmd_decode_pkg

// ===== logic/ms_tick.sv
`timescale 1ns/1ps
// Divider that yields a one-cycle pulse every millisecond.
module ms_tick #(
	parameter int DIV = 20000
) (
	input  wire logic clock,   // System clock
	input  wire logic sys_rst, // Sync reset
	input  wire logic run,     // Count only while high
	output logic      tick     // One-cycle pulse per ms
);
	logic [$clog2(DIV)-1:0] cnt_r;
	wire                    at_end = (cnt_r == ($clog2(DIV))'(DIV - 1));

	always_ff @(posedge clock)
	begin
		if (sys_rst || !run || at_end)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			tick <= 1'b0;
		else
			tick <= run && at_end;
	end

endmodule : ms_tick

// ===== logic/disk_command_decoder.sv
`timescale 1ns/1ps
module disk_command_decoder #(
	parameter bit FAST_STEP   = 1'b0, // Fast step-rate variant
	parameter int SPINUP_MS   = 6     // Spin-up wait, ms
) (
	input  wire logic       clock,                // 20 MHz clock
	input  wire logic       sys_rst,              // Sync reset, active high
	input  wire logic       cmd_wr,               // Host command write strobe
	input  wire logic [7:0] cmd_data,             // Command byte
	input  wire logic       exec_done,            // Execution engine finished
	input  wire logic       exec_error,           // Error flag with exec_done
	input  wire logic       break_met,            // Force interrupt condition met
	output logic [7:0]      cmd_r,                // Command holding register
	output logic [7:0]      status_r,             // Status: busy, error
	output logic            intrq_r,              // Completion interrupt pulse
	output logic [2:0]      cmd_class_r,          // Command type
	output logic            exec_start_r,         // Execution may proceed
	output logic            spinup_r,             // Spin-up sequence active
	output logic            verify_r,             // Verify on destination
	output logic [1:0]      step_interval_sel_r,  // Step rate select
	output logic [15:0]     step_cycles_r,        // Step interval, ms ticks
	output logic            track_update_r,       // Update track per step
	output logic            multi_sector_r,       // Multiple-sector operation
	output logic            deleted_data_mark_r,  // Write deleted mark
	output logic [3:0]      break_condition_bits_r, // Force interrupt selects
	output logic            type3_bit3_bad_r      // Host set bit 3 on type three
);

	// ****************************************
	// Decode
	// ****************************************
	// Keys 0000 to 0111 fall through to type one
	function automatic cmd_decode_pkg::cmd_class_type classify(input logic [7:0] c);
		logic [3:0] k;
		k = c[7:4];
		if (k == cmd_decode_pkg::KEY_FORCE)
			classify = cmd_decode_pkg::CMD_TYPE4;
		else if (k == cmd_decode_pkg::KEY_RD_ADDR || k == cmd_decode_pkg::KEY_RD_TRACK
			|| k == cmd_decode_pkg::KEY_WR_TRACK)
			classify = cmd_decode_pkg::CMD_TYPE3;
		else if (k[3:1] == cmd_decode_pkg::KEY_RD_SECT || k[3:1] == cmd_decode_pkg::KEY_WR_SECT)
			classify = cmd_decode_pkg::CMD_TYPE2;
		else
			classify = cmd_decode_pkg::CMD_TYPE1;
	endfunction : classify

	// Result is in milliseconds; step_cycles_r carries it unscaled
	function automatic logic [15:0] step_ms(input logic [1:0] sel);
		unique case (sel)
			2'b00: step_ms = 16'(FAST_STEP ? cmd_decode_pkg::FAST_MS_0 : cmd_decode_pkg::STD_MS_0);
			2'b01: step_ms = 16'(FAST_STEP ? cmd_decode_pkg::FAST_MS_1 : cmd_decode_pkg::STD_MS_1);
			2'b10: step_ms = 16'(FAST_STEP ? cmd_decode_pkg::FAST_MS_2 : cmd_decode_pkg::STD_MS_2);
			2'b11: step_ms = 16'(FAST_STEP ? cmd_decode_pkg::FAST_MS_3 : cmd_decode_pkg::STD_MS_3);
		endcase
	endfunction : step_ms

	// ****************************************
	// Acceptance
	// ****************************************
	// Busy gates every write except force interrupt
	cmd_decode_pkg::seq_state_type state_r, state_nxt;
	wire cmd_decode_pkg::cmd_class_type new_class = classify(cmd_data);
	wire busy     = status_r[cmd_decode_pkg::BIT_BUSY];
	wire is_force = (new_class == cmd_decode_pkg::CMD_TYPE4);
	wire accept   = cmd_wr && (!busy || is_force);
	wire start_op = accept && !is_force;
	wire nk_step  = (cmd_data[7:5] == cmd_decode_pkg::KEY_STEP)
		|| (cmd_data[7:5] == cmd_decode_pkg::KEY_STEP_IN)
		|| (cmd_data[7:5] == cmd_decode_pkg::KEY_STEP_OUT);
	wire nk_type1 = (new_class == cmd_decode_pkg::CMD_TYPE1);
	wire nk_type2 = (new_class == cmd_decode_pkg::CMD_TYPE2);
	wire nk_wsect = (cmd_data[7:5] == cmd_decode_pkg::KEY_WR_SECT);
	wire need_spin = !cmd_data[cmd_decode_pkg::BIT_SPINUP_INH] && (nk_type1 || nk_type2 ||
		new_class == cmd_decode_pkg::CMD_TYPE3);
	wire finish   = (state_r == cmd_decode_pkg::ST_EXEC) && exec_done;
	wire force_end = accept && is_force; // Abort current and complete now

	// ****************************************
	// Interrupt request
	// ****************************************
	// Break watch only runs once a force command has left the block idle
	wire break_fire = break_met && !busy && (cmd_class_r == cmd_decode_pkg::CMD_TYPE4);
	wire irq_event  = finish || force_end || break_fire;
	wire ms_pulse;
	logic [15:0] spin_cnt_r;

	// ****************************************
	// Millisecond time base
	// ****************************************
	// Divider only runs during spin-up, so every wait starts from a clean count
	ms_tick #(
		.DIV (cmd_decode_pkg::CYC_PER_MS)
	) u_ms (
		.clock   (clock),
		.sys_rst (sys_rst),
		.run     (state_r == cmd_decode_pkg::ST_SPINUP),
		.tick    (ms_pulse)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			cmd_decode_pkg::ST_IDLE:
				if (start_op)
					state_nxt = need_spin ? cmd_decode_pkg::ST_SPINUP : cmd_decode_pkg::ST_EXEC;
			cmd_decode_pkg::ST_SPINUP:
				if (ms_pulse && spin_cnt_r == 16'(SPINUP_MS - 1))
					state_nxt = cmd_decode_pkg::ST_EXEC;
			cmd_decode_pkg::ST_EXEC:
				if (exec_done)
					state_nxt = cmd_decode_pkg::ST_IDLE;
			// Spare code, never entered; falls back to idle
			cmd_decode_pkg::ST_DONE:
				state_nxt = cmd_decode_pkg::ST_IDLE;
		endcase
		// Force interrupt overrides the sequencer in every state
		if (force_end)
			state_nxt = cmd_decode_pkg::ST_IDLE;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			state_r <= cmd_decode_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock)
	begin
		// Whole milliseconds of the current spin-up wait
		if (sys_rst || state_r != cmd_decode_pkg::ST_SPINUP)
			spin_cnt_r <= '0;
		else if (ms_pulse)
			spin_cnt_r <= spin_cnt_r + 16'h0001;
	end

	// ****************************************
	// Command register and flags
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cmd_r                  <= cmd_decode_pkg::CMD_RESET;
			cmd_class_r            <= cmd_decode_pkg::CMD_NONE;
			verify_r               <= 1'b0;
			step_interval_sel_r    <= 2'b00;
			step_cycles_r          <= 16'h0000;
			track_update_r         <= 1'b0;
			multi_sector_r         <= 1'b0;
			deleted_data_mark_r    <= 1'b0;
			break_condition_bits_r <= 4'h0;
			type3_bit3_bad_r       <= 1'b0;
		end
		// Fields that do not apply to the new command read as zero
		else if (accept)
		begin
			cmd_r               <= cmd_data;
			cmd_class_r         <= new_class;
			verify_r            <= nk_type1 && cmd_data[cmd_decode_pkg::BIT_VERIFY];
			step_interval_sel_r <= nk_type1 ? cmd_data[1:0] : 2'b00;
			step_cycles_r       <= nk_type1 ? step_ms(cmd_data[1:0]) : 16'h0000;
			track_update_r      <= nk_step && cmd_data[cmd_decode_pkg::BIT_UPDATE];
			multi_sector_r      <= nk_type2 && cmd_data[cmd_decode_pkg::BIT_MULTI];
			deleted_data_mark_r <= nk_wsect && cmd_data[cmd_decode_pkg::BIT_DELETED];
			break_condition_bits_r <= is_force ? cmd_data[3:0] : 4'h0;
			type3_bit3_bad_r    <= (new_class == cmd_decode_pkg::CMD_TYPE3)
				&& cmd_data[cmd_decode_pkg::BIT_SPINUP_INH];
		end
	end

	// ****************************************
	// Status, interrupt, execution handshake
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			status_r     <= cmd_decode_pkg::STATUS_RESET;
			intrq_r      <= 1'b0;
			exec_start_r <= 1'b0;
			spinup_r     <= 1'b0;
		end
		else
		begin
			intrq_r      <= irq_event;
			exec_start_r <= (state_nxt == cmd_decode_pkg::ST_EXEC);
			spinup_r     <= (state_nxt == cmd_decode_pkg::ST_SPINUP);
			// A start needs busy clear, so it never meets a finish
			if (start_op)
			begin
				status_r[cmd_decode_pkg::BIT_BUSY]  <= 1'b1;
				status_r[cmd_decode_pkg::BIT_ERROR] <= 1'b0;
			end
			// Force interrupt alone reports no error; a finish, even one in the same cycle as a force, passes the engine's flag
			else if (finish || force_end)
			begin
				status_r[cmd_decode_pkg::BIT_BUSY]  <= 1'b0;
				status_r[cmd_decode_pkg::BIT_ERROR] <= finish && exec_error;
			end
		end
	end

endmodule : disk_command_decoder

// ===== bench/exec_engine_model.sv
`timescale 1ns/1ps
module exec_engine_model (
	input  wire logic       clock,      // System clock
	input  wire logic       sys_rst,    // Sync reset
	input  wire logic       exec_start, // Command may run
	input  wire logic [3:0] lat,        // Cycles to finish
	input  wire logic       err,        // Finish with error
	output logic            exec_done,  // Finish pulse
	output logic            exec_error  // Valid with exec_done
);
	logic [3:0] cnt_r;
	logic       fired_r;
	// No free help: outside the pulse the error line lies
	assign exec_error = exec_done ? err : ~err;
	always_ff @(posedge clock)
	begin
		if (sys_rst || !exec_start)
		begin
			cnt_r     <= 4'h0;
			fired_r   <= 1'b0;
			exec_done <= 1'b0;
		end
		else if (!fired_r && cnt_r == lat)
		begin
			fired_r   <= 1'b1;
			exec_done <= 1'b1;
		end
		else
		begin
			exec_done <= 1'b0;
			cnt_r     <= cnt_r + 4'h1;
		end
	end
endmodule : exec_engine_model

// ===== bench/disk_command_decoder_chk.sv
`timescale 1ns/1ps
module disk_command_decoder_chk (
	input wire logic       clock,               // Clock
	input wire logic       sys_rst,             // Reset
	input wire logic       cmd_wr,              // Write strobe
	input wire logic [7:0] cmd_data,            // Command byte
	input wire logic       exec_done,           // Engine done
	input wire logic       exec_error,          // Engine error
	input wire logic [7:0] cmd_r,               // Held command
	input wire logic [7:0] status_r,            // Status
	input wire logic       intrq_r,             // Interrupt
	input wire logic [2:0] cmd_class_r,         // Type
	input wire logic       exec_start_r,        // Running
	input wire logic       spinup_r,            // Spin-up
	input wire logic       verify_r,            // Verify
	input wire logic [1:0] step_interval_sel_r, // Step rate
	input wire logic       track_update_r,      // Track update
	input wire logic       multi_sector_r,      // Multi sector
	input wire logic       deleted_data_mark_r  // Deleted mark
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	wire logic take = cmd_wr && !status_r[0];
	wire logic frc = cmd_wr && cmd_data[7:4] == 4'hd;
	load_idle_a: assert property (take && !frc |=>
		cmd_r == $past(cmd_data) && status_r[0])
		else $error("idle command not loaded");
	busy_refuse_a: assert property (status_r[0] && cmd_wr && !frc |=>
		$stable(cmd_r))
		else $error("command loaded while busy");
	busy_run_a: assert property (exec_start_r || spinup_r |-> status_r[0])
		else $error("busy clear while running");
	done_irq_a: assert property (exec_done && exec_start_r && !cmd_wr |=>
		intrq_r && !status_r[0])
		else $error("finish gave no interrupt");
	done_status_a: assert property (exec_done && exec_start_r && !cmd_wr |=>
		status_r[1] == $past(exec_error))
		else $error("error status wrong");
	force_load_a: assert property (frc |=>
		cmd_r == $past(cmd_data) && cmd_class_r == 3'h4)
		else $error("force command not loaded");
	force_stop_a: assert property (frc && status_r[0] |=>
		intrq_r && !status_r[0])
		else $error("force did not stop command");
	spin_gate_a: assert property (take && !cmd_data[7] |=> cmd_class_r == 3'h1
		&& spinup_r == !$past(cmd_data[3]) && exec_start_r == $past(cmd_data[3]))
		else $error("spin-up choice wrong");
	type1_flags_a: assert property (take && !cmd_data[7] |=>
		verify_r == $past(cmd_data[2]) && step_interval_sel_r == $past(cmd_data[1:0]))
		else $error("type one flags wrong");
	step_update_a: assert property (take && !cmd_data[7] |=>
		track_update_r == ($past(cmd_data[4]) && $past(cmd_data[6:5]) != 2'b00))
		else $error("track update flag wrong");
	sector_flags_a: assert property (take && cmd_data[7:6] == 2'b10 |=>
		cmd_class_r == 3'h2 && multi_sector_r == $past(cmd_data[4])
		&& deleted_data_mark_r == ($past(cmd_data[0]) && $past(cmd_data[5])))
		else $error("sector flags wrong");
	type3_class_a: assert property (take && cmd_data[7:6] == 2'b11 && !frc |=>
		cmd_class_r == 3'h3)
		else $error("type three not classed");
endmodule : disk_command_decoder_chk

bind disk_command_decoder disk_command_decoder_chk chk_u (.clock, .sys_rst, .cmd_wr, .cmd_data,
	.exec_done, .exec_error, .cmd_r, .status_r, .intrq_r, .cmd_class_r, .exec_start_r, .spinup_r,
	.verify_r, .step_interval_sel_r, .track_update_r, .multi_sector_r, .deleted_data_mark_r);

// ===== bench/disk_command_decoder_bench.sv
`timescale 1ns/1ps
module disk_command_decoder_bench;
	typedef struct packed {logic [7:0] cmd; logic [9:0] fl; logic [4:0] ms;} row_type;
	// Flags: type, spin-up, verify, rate, update, multi, deleted
	row_type rows [10] = '{'{8'h00, 10'h0c0, 5'd6}, '{8'h1d, 10'h0a8, 5'd12},
		'{8'h3e, 10'h0b4, 5'd20}, '{8'h4b, 10'h098, 5'd30}, '{8'h7c, 10'h0a4, 5'd6},
		'{8'h98, 10'h102, 5'd0}, '{8'ha9, 10'h101, 5'd0}, '{8'hc0, 10'h1c0, 5'd0},
		'{8'he0, 10'h1c0, 5'd0}, '{8'hf0, 10'h1c0, 5'd0}};
	logic clock, sys_rst, cmd_wr, exec_done, exec_error, break_met, err;
	logic intrq_r, exec_start_r, spinup_r, verify_r, track_update_r;
	logic multi_sector_r, deleted_data_mark_r, type3_bit3_bad_r;
	logic [7:0] cmd_data, cmd_r, status_r;
	logic [2:0] cmd_class_r;
	logic [1:0] step_interval_sel_r;
	logic [15:0] step_cycles_r, fast_cycles;
	logic [3:0] break_condition_bits_r, lat;
	int mismatches = 0;
	int n_compared = 0;
	int fast_ms [4] = '{cmd_decode_pkg::FAST_MS_0, cmd_decode_pkg::FAST_MS_1,
		cmd_decode_pkg::FAST_MS_2, cmd_decode_pkg::FAST_MS_3};
	wire logic [9:0] seen = {cmd_class_r, spinup_r, verify_r, step_interval_sel_r,
		track_update_r, multi_sector_r, deleted_data_mark_r};
	disk_command_decoder #(.FAST_STEP(1'b0), .SPINUP_MS(1)) dut_u (.clock, .sys_rst, .cmd_wr,
		.cmd_data, .exec_done, .exec_error, .break_met, .cmd_r, .status_r, .intrq_r,
		.cmd_class_r, .exec_start_r, .spinup_r, .verify_r, .step_interval_sel_r, .step_cycles_r,
		.track_update_r, .multi_sector_r, .deleted_data_mark_r, .break_condition_bits_r,
		.type3_bit3_bad_r);
	exec_engine_model eng_u (.clock, .sys_rst, .exec_start(exec_start_r), .lat, .err,
		.exec_done, .exec_error);
	// Second copy on the fast step table; it tracks the first cycle for cycle
	disk_command_decoder #(.FAST_STEP(1'b1), .SPINUP_MS(1)) fast_u (.clock, .sys_rst, .cmd_wr,
		.cmd_data, .exec_done, .exec_error, .break_met, .cmd_r(), .status_r(), .intrq_r(),
		.cmd_class_r(), .exec_start_r(), .spinup_r(), .verify_r(), .step_interval_sel_r(),
		.step_cycles_r(fast_cycles), .track_update_r(), .multi_sector_r(),
		.deleted_data_mark_r(), .break_condition_bits_r(), .type3_bit3_bad_r());
	// ****************************************
	// Tasks
	// ****************************************
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	function automatic logic [15:0] fast_exp(input row_type r);
		fast_exp = (r.fl[9:7] == 3'h1) ? 16'(fast_ms[r.cmd[1:0]]) : 16'h0;
	endfunction : fast_exp
	task automatic issue(input logic [7:0] c);
		@(negedge clock);
		cmd_wr = 1'b1;
		cmd_data = c;
		@(negedge clock);
		cmd_wr = 1'b0;
	endtask : issue
	// Spin-up alone is 20000 cycles, hence the wide bound
	task automatic wait_irq;
		int n;
		n = 0;
		while (intrq_r !== 1'b1 && n < 25000)
		begin
			@(negedge clock);
			n++;
		end
		cmp("intrq", 16'h1, {15'h0, intrq_r});
	endtask : wait_irq
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// ****************************************
	// Sequence
	// ****************************************
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		// Tests need about 80k cycles, mostly four spin-up waits
		#4_500_000;
		mismatches++;
		complete_run();
	end
	initial
	begin
		sys_rst = 1'b1;
		cmd_wr = 1'b0;
		cmd_data = 8'h00;
		break_met = 1'b0;
		err = 1'b0;
		lat = 4'h2;
		repeat (3) @(negedge clock);
		sys_rst = 1'b0;
		cmp("status", 16'h0, {8'h0, status_r});
		for (int i = 0; i < 10; i++)
		begin
			err = i[0];
			lat = i[3:0];
			issue(rows[i].cmd);
			cmp("flags", {6'h0, rows[i].fl}, {6'h0, seen});
			cmp("cycles", {11'h0, rows[i].ms}, step_cycles_r);
			cmp("fast cycles", fast_exp(rows[i]), fast_cycles);
			cmp("bit3 flag", 16'h0, {15'h0, type3_bit3_bad_r});
			cmp("busy", 16'h1, {15'h0, status_r[0]});
			wait_irq();
			cmp("status", {14'h0, err, 1'b0}, {8'h0, status_r});
			$display("row %0d done", i);
		end
		lat = 4'hf;
		err = 1'b0;
		issue(8'h08);
		issue(8'h98);
		cmp("refused", 16'h08, {8'h0, cmd_r});
		issue(8'hd5);
		cmp("force", 16'hd5, {8'h0, cmd_r});
		cmp("irq", 16'h1, {15'h0, intrq_r});
		cmp("busy", 16'h0, {15'h0, status_r[0]});
		cmp("brk", 16'h5, {12'h0, break_condition_bits_r});
		@(negedge clock);
		break_met = 1'b1;
		wait_irq();
		break_met = 1'b0;
		$display("force test done");
		issue(8'h18);
		sys_rst = 1'b1;
		@(negedge clock);
		sys_rst = 1'b0;
		cmp("rst status", 16'h0, {8'h0, status_r});
		issue(8'h5c);
		cmp("after rst", 16'h5c, {8'h0, cmd_r});
		wait_irq();
		$display("reset test done");
		complete_run();
	end
endmodule : disk_command_decoder_bench
